// [spr_pkg.sv]
// constants shared by the status pin routing block
package spr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] SPR_STAT_EN_ADDR = 8'h14;
  localparam logic [7:0] SPR_ACT_SEL_ADDR = 8'h15;

  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] SPR_STAT_EN_RST  = 8'h3C;
  localparam logic [7:0] SPR_ACT_SEL_RST  = 8'hFF;
  localparam logic [7:0] SPR_STAT_EN_WMSK = 8'h3F;
  localparam logic [7:0] SPR_ACT_SEL_WMSK = 8'h1F;
  localparam logic [7:0] SPR_UNMAPPED_RD  = 8'h00;

  // ==========================================================
  // status pin enable fields
  localparam int SPR_IRQ_PIN_BIT   = 0;
  localparam int SPR_LOCK_LOSS_PIN_EN_BIT   = 1;
  localparam int SPR_BAD1_PIN_BIT  = 2;
  localparam int SPR_BAD2_PIN_BIT  = 3;
  localparam int SPR_BAD3_PIN_BIT  = 4;
  localparam int SPR_ALARM_PIN_BIT = 5;

  // ==========================================================
  // active pin and select source fields
  localparam int SPR_SEL_SRC_BIT   = 0;
  localparam int SPR_ACT1_PIN_BIT  = 1;
  localparam int SPR_ACT2_PIN_BIT  = 2;
  localparam int SPR_ACT3_PIN_BIT  = 3;
  localparam int SPR_ACT4_PIN_BIT  = 4;

  // ==========================================================
  // pin slots in the driver array
  localparam int SPR_NUM_PINS  = 10;
  localparam int SPR_SLOT_SHR  = 0;
  localparam int SPR_SLOT_LOL  = 1;
  localparam int SPR_SLOT_BAD1 = 2;
  localparam int SPR_SLOT_BAD2 = 3;
  localparam int SPR_SLOT_BAD3 = 4;
  localparam int SPR_SLOT_ACT1 = 5;
  localparam int SPR_SLOT_ACT2 = 6;
  localparam int SPR_SLOT_ACT3 = 7;
  localparam int SPR_SLOT_ACT4 = 8;
  localparam int SPR_SLOT_SPARE = 9;

endpackage : spr_pkg

// [spr_pin_drv.sv]
// one polarity-controlled tristate status pin driver
`timescale 1ns/100ps
module spr_pin_drv (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // routed status
  input  wire logic status,
  input  wire logic active_high,
  input  wire logic drive_en,
  // pad
  output logic      pad_o,
  output logic      pad_oe
);

  // ==========================================================
  // polarity and enable
  logic pad_d;

  // pol 1 passes status, pol 0 inverts it
  assign pad_d = status ~^ active_high;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pad_o  <= 1'b0;
      pad_oe <= 1'b0;
    end else begin
      pad_o  <= pad_d;
      pad_oe <= drive_en;
    end
  end

endmodule : spr_pin_drv

// [spr_status_pin_routing.sv]
// status pin routing and input select source control
`timescale 1ns/100ps
// What this block does
// - status pin enable register resets to 0x3C.
// - interrupt pin enable drives interrupt status on shared pin, alarm ignored.
// - interrupt enable clear, alarm enable set: combined alarm drives shared pin.
// - both shared pin enables clear: shared pin tristated.
// - bad-clock enables tristate or drive each input's bad-clock pin.
// - lock-loss enable tristates or drives lock-loss status on its pin.
// - active enables one and two tristate or drive their indicators.
// - input-four indicator enable acts only while its shared pin is output.
// - input-three indicator enable acts only while its shared pin is output.
// - source choice applies only under manual input selection.
// - source bit clear: register field picks input, pins ignored.
// - source bit set: the two select pins pick the input.
// - active indicator enables matter only while source bit is one.
// - active pin and select source register resets to 0xFF.
// - each routed status uses its group polarity, 0 low, 1 high.
module spr_status_pin_routing (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // register port from the serial management decoder
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wr_data,
  output logic      [7:0] reg_rd_data,
  // internal status
  input  wire logic       irq_status,
  input  wire logic       combined_alarm,
  input  wire logic       in1_bad_status,
  input  wire logic       in2_bad_status,
  input  wire logic       in3_bad_status,
  input  wire logic       lock_loss_irq_status,
  input  wire logic       in1_active_status,
  input  wire logic       in2_active_status,
  input  wire logic       in3_active_status,
  input  wire logic       in4_active_status,
  // polarity controls
  input  wire logic       irq_polarity,
  input  wire logic       bad_alarm_polarity,
  input  wire logic       lock_loss_polarity,
  input  wire logic       active_indicator_polarity,
  // input clock selection
  input  wire logic       manual_select_mode,
  input  wire logic [1:0] manual_input_select_field,
  input  wire logic [1:0] input_select_inputs_i,
  output logic      [1:0] selected_input,
  output logic            selected_input_valid,
  // dedicated status pins
  output logic            irq_alarm_shared_pin_o,
  output logic            irq_alarm_shared_pin_oe,
  output logic            lock_loss_out_o,
  output logic            lock_loss_out_oe,
  output logic            in1_bad_out_o,
  output logic            in1_bad_out_oe,
  output logic            in2_bad_out_o,
  output logic            in2_bad_out_oe,
  output logic            in3_bad_out_o,
  output logic            in3_bad_out_oe,
  output logic            in1_active_out_o,
  output logic            in1_active_out_oe,
  output logic            in2_active_out_o,
  output logic            in2_active_out_oe,
  // pins shared with the select inputs
  output logic            in3_active_out_o,
  output logic            in3_active_out_oe,
  output logic            in4_active_out_o,
  output logic            in4_active_out_oe
);

  localparam int NP = spr_pkg::SPR_NUM_PINS - 1; // spare slot unbuilt

  // ==========================================================
  // registers
  logic [7:0] stat_en_q;
  logic [7:0] stat_en_d;
  logic [7:0] act_sel_q;
  logic [7:0] act_sel_d;
  logic [7:0] rd_data_d;
  logic       wr_stat;
  logic       wr_act;

  assign wr_stat = reg_wr_en && (reg_addr == spr_pkg::SPR_STAT_EN_ADDR);
  assign wr_act  = reg_wr_en && (reg_addr == spr_pkg::SPR_ACT_SEL_ADDR);

  // reserved bits keep their reset value whatever is written
  assign stat_en_d = wr_stat ?
    ((reg_wr_data & spr_pkg::SPR_STAT_EN_WMSK) |
     (spr_pkg::SPR_STAT_EN_RST & ~spr_pkg::SPR_STAT_EN_WMSK)) :
    stat_en_q;
  assign act_sel_d = wr_act ?
    ((reg_wr_data & spr_pkg::SPR_ACT_SEL_WMSK) |
     (spr_pkg::SPR_ACT_SEL_RST & ~spr_pkg::SPR_ACT_SEL_WMSK)) :
    act_sel_q;

  assign rd_data_d =
    (reg_addr == spr_pkg::SPR_STAT_EN_ADDR) ? stat_en_q :
    (reg_addr == spr_pkg::SPR_ACT_SEL_ADDR) ? act_sel_q :
    spr_pkg::SPR_UNMAPPED_RD;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stat_en_q   <= spr_pkg::SPR_STAT_EN_RST;
      act_sel_q   <= spr_pkg::SPR_ACT_SEL_RST;
      reg_rd_data <= spr_pkg::SPR_UNMAPPED_RD;
    end else begin
      stat_en_q <= stat_en_d;
      act_sel_q <= act_sel_d;
      if (reg_rd_en) begin
        reg_rd_data <= rd_data_d;
      end
    end
  end

  // ==========================================================
  // select pin synchroniser, stage one feeds stage two only
  logic [1:0] sel_meta_q;
  logic [1:0] sel_sync_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_meta_q <= 2'h0;
      sel_sync_q <= 2'h0;
    end else begin
      sel_meta_q <= input_select_inputs_i;
      sel_sync_q <= sel_meta_q;
    end
  end

  // ==========================================================
  // input clock selection
  logic       src_pins;
  logic [1:0] sel_d;

  assign src_pins = act_sel_q[spr_pkg::SPR_SEL_SRC_BIT];
  // outside manual mode the select value is meaningless, so hold zero
  assign sel_d = !manual_select_mode ? 2'h0 :
                 src_pins ? sel_sync_q :
                 manual_input_select_field;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      selected_input       <= 2'h0;
      selected_input_valid <= 1'b0;
    end else begin
      selected_input       <= sel_d;
      selected_input_valid <= manual_select_mode;
    end
  end

  // ==========================================================
  // routing of status, polarity and enables
  logic          irq_on;
  logic          shared_out;
  logic          act_gate;
  logic [NP-1:0] st;
  logic [NP-1:0] pol;
  logic [NP-1:0] en;
  logic [NP-1:0] pin_o;
  logic [NP-1:0] pin_oe;

  assign irq_on = stat_en_q[spr_pkg::SPR_IRQ_PIN_BIT];
  // shared select pins are inputs while manual mode reads them
  assign shared_out = !(manual_select_mode && src_pins);
  assign act_gate   = src_pins;

  assign st[spr_pkg::SPR_SLOT_SHR]  = irq_on ? irq_status
                                           : combined_alarm;
  assign pol[spr_pkg::SPR_SLOT_SHR] = irq_on ? irq_polarity
                                           : bad_alarm_polarity;
  assign en[spr_pkg::SPR_SLOT_SHR]  = irq_on |
    stat_en_q[spr_pkg::SPR_ALARM_PIN_BIT];

  assign st[spr_pkg::SPR_SLOT_LOL]  = lock_loss_irq_status;
  assign pol[spr_pkg::SPR_SLOT_LOL] = lock_loss_polarity;
  assign en[spr_pkg::SPR_SLOT_LOL]  =
    stat_en_q[spr_pkg::SPR_LOCK_LOSS_PIN_EN_BIT];

  assign st[spr_pkg::SPR_SLOT_BAD1]  = in1_bad_status;
  assign st[spr_pkg::SPR_SLOT_BAD2]  = in2_bad_status;
  assign st[spr_pkg::SPR_SLOT_BAD3]  = in3_bad_status;
  assign pol[spr_pkg::SPR_SLOT_BAD1] = bad_alarm_polarity;
  assign pol[spr_pkg::SPR_SLOT_BAD2] = bad_alarm_polarity;
  assign pol[spr_pkg::SPR_SLOT_BAD3] = bad_alarm_polarity;
  assign en[spr_pkg::SPR_SLOT_BAD1]  =
    stat_en_q[spr_pkg::SPR_BAD1_PIN_BIT];
  assign en[spr_pkg::SPR_SLOT_BAD2]  =
    stat_en_q[spr_pkg::SPR_BAD2_PIN_BIT];
  assign en[spr_pkg::SPR_SLOT_BAD3]  =
    stat_en_q[spr_pkg::SPR_BAD3_PIN_BIT];

  assign st[spr_pkg::SPR_SLOT_ACT1]  = in1_active_status;
  assign st[spr_pkg::SPR_SLOT_ACT2]  = in2_active_status;
  assign st[spr_pkg::SPR_SLOT_ACT3]  = in3_active_status;
  assign st[spr_pkg::SPR_SLOT_ACT4]  = in4_active_status;
  assign pol[spr_pkg::SPR_SLOT_ACT1] = active_indicator_polarity;
  assign pol[spr_pkg::SPR_SLOT_ACT2] = active_indicator_polarity;
  assign pol[spr_pkg::SPR_SLOT_ACT3] = active_indicator_polarity;
  assign pol[spr_pkg::SPR_SLOT_ACT4] = active_indicator_polarity;
  assign en[spr_pkg::SPR_SLOT_ACT1]  = act_gate &
    act_sel_q[spr_pkg::SPR_ACT1_PIN_BIT];
  assign en[spr_pkg::SPR_SLOT_ACT2]  = act_gate &
    act_sel_q[spr_pkg::SPR_ACT2_PIN_BIT];
  assign en[spr_pkg::SPR_SLOT_ACT3]  = act_gate & shared_out &
    act_sel_q[spr_pkg::SPR_ACT3_PIN_BIT];
  assign en[spr_pkg::SPR_SLOT_ACT4]  = act_gate & shared_out &
    act_sel_q[spr_pkg::SPR_ACT4_PIN_BIT];

  for (genvar g = 0; g < NP; g++) begin : g_pin
    spr_pin_drv u_drv (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .status      (st[g]),
      .active_high (pol[g]),
      .drive_en    (en[g]),
      .pad_o       (pin_o[g]),
      .pad_oe      (pin_oe[g])
    );
  end

  assign irq_alarm_shared_pin_o  = pin_o[spr_pkg::SPR_SLOT_SHR];
  assign irq_alarm_shared_pin_oe = pin_oe[spr_pkg::SPR_SLOT_SHR];
  assign lock_loss_out_o         = pin_o[spr_pkg::SPR_SLOT_LOL];
  assign lock_loss_out_oe        = pin_oe[spr_pkg::SPR_SLOT_LOL];
  assign in1_bad_out_o           = pin_o[spr_pkg::SPR_SLOT_BAD1];
  assign in1_bad_out_oe          = pin_oe[spr_pkg::SPR_SLOT_BAD1];
  assign in2_bad_out_o           = pin_o[spr_pkg::SPR_SLOT_BAD2];
  assign in2_bad_out_oe          = pin_oe[spr_pkg::SPR_SLOT_BAD2];
  assign in3_bad_out_o           = pin_o[spr_pkg::SPR_SLOT_BAD3];
  assign in3_bad_out_oe          = pin_oe[spr_pkg::SPR_SLOT_BAD3];
  assign in1_active_out_o        = pin_o[spr_pkg::SPR_SLOT_ACT1];
  assign in1_active_out_oe       = pin_oe[spr_pkg::SPR_SLOT_ACT1];
  assign in2_active_out_o        = pin_o[spr_pkg::SPR_SLOT_ACT2];
  assign in2_active_out_oe       = pin_oe[spr_pkg::SPR_SLOT_ACT2];
  assign in3_active_out_o        = pin_o[spr_pkg::SPR_SLOT_ACT3];
  assign in3_active_out_oe       = pin_oe[spr_pkg::SPR_SLOT_ACT3];
  assign in4_active_out_o        = pin_o[spr_pkg::SPR_SLOT_ACT4];
  assign in4_active_out_oe       = pin_oe[spr_pkg::SPR_SLOT_ACT4];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  stat_reset_a: assert property ($rose(rst_n) |->
    stat_en_q == 8'h3C) else $error("status enable reset wrong");
  act_reset_a: assert property ($rose(rst_n) |->
    act_sel_q == 8'hFF) else $error("active select reset wrong");
  shared_irq_a: assert property ($past(rst_n) && $past(irq_on) |->
    irq_alarm_shared_pin_oe && (irq_alarm_shared_pin_o ==
    ($past(irq_status) ~^ $past(irq_polarity))))
    else $error("shared pin not showing interrupt");
  shared_alarm_a: assert property ($past(rst_n) &&
    !$past(irq_on) && $past(stat_en_q[5]) |-> irq_alarm_shared_pin_oe &&
    (irq_alarm_shared_pin_o ==
    ($past(combined_alarm) ~^ $past(bad_alarm_polarity))))
    else $error("shared pin not showing alarm");
  shared_off_a: assert property ($past(rst_n) &&
    $past(stat_en_q[5:0] & 6'h21) == 6'h00 |-> !irq_alarm_shared_pin_oe)
    else $error("shared pin driven while off");
  bad_pin_a: assert property ($past(rst_n) |->
    in2_bad_out_oe == $past(stat_en_q[3]) &&
    (!in2_bad_out_oe || in2_bad_out_o ==
    ($past(in2_bad_status) ~^ $past(bad_alarm_polarity))))
    else $error("bad clock pin wrong");
  lock_loss_pin_en_a: assert property ($past(rst_n) |->
    lock_loss_out_oe == $past(stat_en_q[1]))
    else $error("lock loss enable wrong");
  act_gate_a: assert property ($past(rst_n) &&
    !$past(act_sel_q[0]) |-> !in1_active_out_oe && !in2_active_out_oe &&
    !in3_active_out_oe && !in4_active_out_oe)
    else $error("active pin driven");
  act_one_a: assert property ($past(rst_n) &&
    $past(act_sel_q[1:0]) == 2'h3 |-> in1_active_out_oe)
    else $error("active one off");
  shared_in_a: assert property ($past(rst_n) &&
    $past(manual_select_mode) && $past(act_sel_q[0]) |->
    !in3_active_out_oe && !in4_active_out_oe)
    else $error("select pin driven as output");
  sel_reg_a: assert property (manual_select_mode &&
    !act_sel_q[0] |=> selected_input == $past(manual_input_select_field))
    else $error("register select ignored");
  sel_pin_a: assert property ($past(rst_n, 2) && $past(rst_n) &&
    manual_select_mode && act_sel_q[0] |=>
    selected_input == $past(input_select_inputs_i, 3))
    else $error("pin select ignored");
  sel_auto_a: assert property (!manual_select_mode |=>
    !selected_input_valid && selected_input == 2'h0)
    else $error("select active outside manual");

  irq_seen_c:   cover property (irq_on && irq_alarm_shared_pin_oe);
  alarm_seen_c: cover property (!irq_on && irq_alarm_shared_pin_oe);
  pin_sel_c:    cover property (manual_select_mode && src_pins);
  act_off_c:    cover property (!src_pins ##1 !in1_active_out_oe);

endmodule : spr_status_pin_routing

// [spr_board_mon.sv]
// board model resolving the select pads shared with active outputs
`timescale 1ns/100ps
module spr_board_mon (
  // device side of the shared pads
  input  wire logic [1:0] dev_o,
  input  wire logic [1:0] dev_oe,
  // board select drivers
  input  wire logic       sel_drv_en,
  input  wire logic [1:0] sel_val,
  // resolved pad levels
  output logic      [1:0] pad
);
  // ==========================================================
  // pad resolution
  // released pads sit at the board pull-up, contention shows as x
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (dev_oe[i] && sel_drv_en) pad[i] = 1'bx;
      else if (dev_oe[i]) pad[i] = dev_o[i];
      else if (sel_drv_en) pad[i] = sel_val[i];
      else pad[i] = 1'b1;
    end
  end
endmodule : spr_board_mon

// [tb.sv]
// self-checking bench for the status pin routing block
`timescale 1ns/100ps
module tb;
  logic        clk_sys, rst_n, reg_wr_en, reg_rd_en, look, rd_now, rd_pend;
  logic  [7:0] reg_addr, reg_wr_data, s_sh, a_sh;
  logic  [9:0] st;
  logic  [3:0] pol;
  logic        manual, sel_drv_en;
  logic  [1:0] field, sel_val;
  logic [31:0] rng;
  wire   [7:0] reg_rd_data;
  wire   [8:0] po, poe;
  wire   [1:0] pad, sel_q;
  wire         sel_vld;
  int          n_mismatch, checks_done;
  typedef struct {string nm; logic [20:0] v; logic [20:0] m;} spr_note_t;
  spr_note_t   q[$];
  logic  [7:0] tbl[8] = '{8'h00, 8'h01, 8'h20, 8'h21, 8'h3F, 8'hC2, 8'h1C,
                         8'h02};

  // ==========================================================
  // design and board model
  spr_status_pin_routing dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .irq_status(st[0]), .combined_alarm(st[1]),
    .in1_bad_status(st[2]), .in2_bad_status(st[3]), .in3_bad_status(st[4]),
    .lock_loss_irq_status(st[5]), .in1_active_status(st[6]),
    .in2_active_status(st[7]), .in3_active_status(st[8]),
    .in4_active_status(st[9]), .irq_polarity(pol[0]),
    .bad_alarm_polarity(pol[1]), .lock_loss_polarity(pol[2]),
    .active_indicator_polarity(pol[3]), .manual_select_mode(manual),
    .manual_input_select_field(field), .input_select_inputs_i(pad),
    .selected_input(sel_q), .selected_input_valid(sel_vld),
    .irq_alarm_shared_pin_o(po[0]), .irq_alarm_shared_pin_oe(poe[0]),
    .lock_loss_out_o(po[1]), .lock_loss_out_oe(poe[1]),
    .in1_bad_out_o(po[2]), .in1_bad_out_oe(poe[2]),
    .in2_bad_out_o(po[3]), .in2_bad_out_oe(poe[3]),
    .in3_bad_out_o(po[4]), .in3_bad_out_oe(poe[4]),
    .in1_active_out_o(po[5]), .in1_active_out_oe(poe[5]),
    .in2_active_out_o(po[6]), .in2_active_out_oe(poe[6]),
    .in3_active_out_o(po[7]), .in3_active_out_oe(poe[7]),
    .in4_active_out_o(po[8]), .in4_active_out_oe(poe[8]));
  spr_board_mon mon_u (.dev_o(po[8:7]), .dev_oe(poe[8:7]),
    .sel_drv_en(sel_drv_en), .sel_val(sel_val), .pad(pad));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // returns {mask, value}; output levels only count while driven
  function automatic logic [41:0] pin_exp();
    logic [8:0] e, o;
    logic [2:0] sl;
    e[0] = s_sh[0] | s_sh[5];
    o[0] = s_sh[0] ? ~(st[0] ^ pol[0]) : ~(st[1] ^ pol[1]);
    e[1] = s_sh[1];
    o[1] = ~(st[5] ^ pol[2]);
    for (int k = 0; k < 3; k++) begin
      e[2+k] = s_sh[2+k];
      o[2+k] = ~(st[2+k] ^ pol[1]);
    end
    for (int k = 0; k < 4; k++) begin
      e[5+k] = a_sh[0] & a_sh[1+k];
      o[5+k] = ~(st[6+k] ^ pol[3]);
    end
    e[8:7] &= {2{~manual}};
    sl = {manual, manual ? (a_sh[0] ? sel_val : field) : 2'h0};
    return {3'h7, 9'h1FF, e, sl, e, o};
  endfunction : pin_exp

  task automatic shadow(input logic [7:0] ad, input logic [7:0] d);
    if (ad == spr_pkg::SPR_STAT_EN_ADDR)
      s_sh = (d & 8'h3F) | (spr_pkg::SPR_STAT_EN_RST & 8'hC0);
    if (ad == spr_pkg::SPR_ACT_SEL_ADDR)
      a_sh = (d & 8'h1F) | (spr_pkg::SPR_ACT_SEL_RST & 8'hE0);
  endtask : shadow

  task automatic wr_pair(input logic [7:0] a0, d0, a1, d1);
    reg_wr_en = 1'b1;
    reg_addr = a0;
    reg_wr_data = d0;
    @(negedge clk_sys);
    reg_addr = a1;
    reg_wr_data = d1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    shadow(a0, d0);
    shadow(a1, d1);
  endtask : wr_pair

  task automatic rd(input logic [7:0] ad, input logic [7:0] e, string nm);
    reg_rd_en = 1'b1;
    reg_addr = ad;
    q.push_back('{nm, {13'h0, e}, 21'hFF});
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    @(negedge clk_sys);
  endtask : rd

  task automatic rd_both();
    rd(spr_pkg::SPR_STAT_EN_ADDR, s_sh, "status enable reg");
    rd(spr_pkg::SPR_ACT_SEL_ADDR, a_sh, "active select reg");
  endtask : rd_both

  task automatic chk_pins(input string nm);
    logic [41:0] x;
    repeat (2) @(negedge clk_sys);
    // board drives the select pads only once the device has let go
    sel_drv_en = manual & a_sh[0];
    repeat (4) @(negedge clk_sys);
    x = pin_exp();
    q.push_back('{nm, x[20:0], x[41:21]});
    look = 1'b1;
    @(negedge clk_sys);
    look = 1'b0;
  endtask : chk_pins

  task automatic rnd_in();
    sel_drv_en = 1'b0;
    rng = xs(rng);
    {st, pol, manual, field} = rng[16:0];
    rng = xs(rng);
    sel_val = rng[1:0];
  endtask : rnd_in

  task automatic do_reset(input int n);
    rst_n = 1'b0;
    sel_drv_en = 1'b0;
    repeat (n) @(negedge clk_sys);
    rst_n = 1'b1;
    s_sh = spr_pkg::SPR_STAT_EN_RST;
    a_sh = spr_pkg::SPR_ACT_SEL_RST;
  endtask : do_reset

  task automatic cmp(input logic [20:0] got);
    spr_note_t n;
    checks_done++;
    if (q.size() == 0) begin
      n_mismatch++;
      $display("ERROR result seen with no expectation");
      return;
    end
    n = q.pop_front();
    if ((got & n.m) !== (n.v & n.m)) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n.nm, n.v & n.m, got & n.m);
    end
  endtask : cmp

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // result watcher
  always @(posedge clk_sys) begin
    rd_now = reg_rd_en;
    #2;
    if (rd_pend) cmp({13'h0, reg_rd_data});
    if (look) cmp({sel_vld, sel_q, poe, po});
    rd_pend = rd_now;
  end

  initial begin
    #200000;
    n_mismatch++;
    $display("ERROR watchdog expired");
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    {rst_n, reg_wr_en, reg_rd_en, look, rd_pend, manual} = '0;
    {reg_addr, reg_wr_data, st, field, sel_drv_en, sel_val} = '0;
    pol = 4'hF;
    rng = 32'hAE42;
    do_reset(20);
    rd(spr_pkg::SPR_STAT_EN_ADDR, 8'h3C, "status enable reset");
    rd(spr_pkg::SPR_ACT_SEL_ADDR, 8'hFF, "active select reset");
    rd(8'h16, spr_pkg::SPR_UNMAPPED_RD, "unmapped read");
    chk_pins("pins after reset");
    for (int i = 0; i < 48; i++) begin
      rnd_in();
      wr_pair(spr_pkg::SPR_STAT_EN_ADDR, i < 8 ? tbl[i] : rng[31:24],
              spr_pkg::SPR_ACT_SEL_ADDR, rng[23:16]);
      chk_pins("pin routing");
      chk_pins("active and select");
      rd_both();
    end
    wr_pair(8'h16, 8'hAA, 8'h13, 8'h55);
    rd_both();
    do_reset(3);
    rd_both();
    wrap_up();
  end
endmodule : tb
